// ===== logic/bit_ops_pkg.sv
// package: opcodes, widths, constants and carriers for the bit unit
package bit_ops_pkg;
  localparam int unsigned WORD_W    = 16;       // register word width
  localparam int unsigned N_MIN     = 1;        // least encoder size code
  localparam int unsigned N_MAX     = 8;        // largest encoder size code
  localparam int unsigned TABLE_MAX = 256;      // 2^N_MAX table bits
  localparam int unsigned POS_W     = 8;        // bit position width
  localparam int unsigned NSZ_W     = 4;        // size code width
  localparam logic [15:0] WORD_ONES = 16'hffff; // register force-on value
  localparam logic [15:0] WORD_ZERO = 16'h0000; // register force-off value
  localparam logic [0:0]  BIT_ON    = 1'h1;     // bit device on
  localparam logic [0:0]  BIT_OFF   = 1'h0;     // bit device off

  // instruction selector, one-hot except OP_NONE, which is all zero
  typedef enum logic [5:0] {
    OP_NONE          = 6'h00,
    OP_UNSIGNED_LE   = 6'h01,
    OP_FORCE_ON      = 6'h02,
    OP_FORCE_OFF     = 6'h04,
    carry_set_instr  = 6'h08,
    carry_clear_instr = 6'h10,
    priority_encode_instr = 6'h20
  } op_e;

  // one instruction request from the sequencer
  typedef struct packed {
    logic                rung_in;   // rung input condition
    op_e                 op;        // instruction
    logic                is_reg;    // operand is a register, not a bit
    logic [WORD_W-1:0]   opnd_a;    // compare operand a
    logic [WORD_W-1:0]   opnd_b;    // compare operand b
    logic [NSZ_W-1:0]    enc_n;     // encoder size code
  } instr_s;

  // write-back towards registers, devices and the rung output; flags leave on their own ports
  typedef struct packed {
    logic                rung_out;  // rung output
    logic                bit_we;    // bit device write
    logic                bit_val;   // bit device value
    logic                word_we;   // register write
    logic [WORD_W-1:0]   word_val;  // register value
    logic                dest_we;   // encoder destination write
    logic [WORD_W-1:0]   dest_val;  // encoder result
  } result_s;
endpackage : bit_ops_pkg

// ===== logic/msb_encoder.sv
// module: priority encoder over a 2^n bit table
`timescale 1ns/100ps
module msb_encoder #(
  parameter int unsigned TBL = bit_ops_pkg::TABLE_MAX,
  parameter int unsigned PW  = bit_ops_pkg::POS_W
) (
  // table and size
  input  wire logic [TBL-1:0]                 table_bits,
  input  wire logic [bit_ops_pkg::NSZ_W-1:0]  size_n,
  // answer
  output logic      [PW-1:0]                  msb_pos,
  output logic                                found
);
  logic [TBL-1:0] valid_mask; // bits inside 2^n

  // mask off table bits beyond the selected size
  genvar g;
  generate
    for (g = 0; g < TBL; g++)
    begin : g_mask
      assign valid_mask[g] = (g < (1 << size_n));
    end
  endgenerate

  // scan upward so the highest on bit wins
  always_comb
  begin
    msb_pos = '0;
    found   = 1'b0;
    for (int i = 0; i < TBL; i++)
    begin
      if (table_bits[i] && valid_mask[i])
      begin
        msb_pos = PW'(i);
        found   = 1'b1;
      end
    end
  end
endmodule : msb_encoder

// ===== logic/plc_bit_compare_encode_unit.sv
// module: compare, force, carry and encode instruction execution
// Contract
// RULE1: comparator on when a<=b, off otherwise/idle
// RULE2: operands compared as unsigned 16-bit words
// RULE3: force-on sets bit, or register to ffff
// RULE4: register force-on sets all sixteen bits
// RULE5: force-off clears bit, or register to zero
// RULE6: forced values persist until later write
// RULE7: carry-set sets carry flag, output on
// RULE8: carry-clear clears carry flag, output on
// RULE9: encoder writes msb position, output on
// RULE10: table starts bit zero, spans words
// RULE11: empty table: no write, off, error set
// RULE12: rung off: nothing changes, output off
`timescale 1ns/100ps
module plc_bit_compare_encode_unit #(
  parameter int unsigned TBL = bit_ops_pkg::TABLE_MAX
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // request from sequencer
  input  wire bit_ops_pkg::instr_s   instr,
  input  wire logic [TBL-1:0]        enc_table,
  // write-back, registered
  output bit_ops_pkg::result_s       result,
  output logic                       carry_flag_bit,
  output logic                       error_flag_bit
);
  // zero bits above the encoder position in a destination word
  localparam int unsigned PAD_W = bit_ops_pkg::WORD_W - bit_ops_pkg::POS_W;

  bit_ops_pkg::result_s          res_ff;    // registered result
  bit_ops_pkg::result_s          nxt_res;   // next result
  logic                          carry_ff;  // system carry flag
  logic                          nxt_carry; // next carry flag
  logic                          err_ff;    // instruction error flag
  logic                          nxt_err;   // next error flag
  logic [bit_ops_pkg::POS_W-1:0] enc_pos;   // highest on bit found
  logic                          enc_found; // any on bit in the window
  logic                          n_ok;      // size code within 1..8
  logic [TBL-1:0]                win_chk;   // table window, checks only

  // encoder over a table laid out from bit zero upward, word by word
  msb_encoder #(
    .TBL (TBL),
    .PW  (bit_ops_pkg::POS_W)
  ) u_msb_encoder ( // see RULE10
    .table_bits (enc_table),
    .size_n     (instr.enc_n),
    .msb_pos    (enc_pos),
    .found      (enc_found)
  );

  // out-of-range size codes are refused and reported like an empty table
  assign n_ok = (instr.enc_n >= bit_ops_pkg::NSZ_W'(bit_ops_pkg::N_MIN)) &&
                (instr.enc_n <= bit_ops_pkg::NSZ_W'(bit_ops_pkg::N_MAX));

  // ones over the 2^n bits that the size code selects; read by checks only,
  // so the encoder answer is judged by a second, independent expression
  assign win_chk = {TBL{1'b1}} >> (TBL - (32'd1 << instr.enc_n));

  // next values: each write is a one-cycle strobe; the targets hold state
  // outside, so a gated-off rung just sends no strobe and forced values stay
  always_comb
  begin
    nxt_res   = '0;        // no strobes, output off; see RULE12 RULE6
    nxt_carry = carry_ff;  // flags kept unless an instruction runs
    nxt_err   = err_ff;    // sticky until reset
    if (instr.rung_in)
    begin
      case (instr.op)
        bit_ops_pkg::OP_UNSIGNED_LE:
        begin
          // unsigned compare, 0..65535
          nxt_res.rung_out = (instr.opnd_a <= instr.opnd_b); // see RULE1 RULE2
        end
        bit_ops_pkg::OP_FORCE_ON:
        begin
          nxt_res.rung_out = 1'b1;
          nxt_res.bit_we   = ~instr.is_reg;              // see RULE3
          nxt_res.bit_val  = bit_ops_pkg::BIT_ON;
          nxt_res.word_we  = instr.is_reg;
          nxt_res.word_val = bit_ops_pkg::WORD_ONES;     // see RULE4
        end
        bit_ops_pkg::OP_FORCE_OFF:
        begin
          nxt_res.rung_out = 1'b1;
          nxt_res.bit_we   = ~instr.is_reg;              // see RULE5
          nxt_res.bit_val  = bit_ops_pkg::BIT_OFF;
          nxt_res.word_we  = instr.is_reg;
          nxt_res.word_val = bit_ops_pkg::WORD_ZERO;
        end
        bit_ops_pkg::carry_set_instr:
        begin
          nxt_res.rung_out = 1'b1;
          nxt_carry        = 1'b1;                       // see RULE7
        end
        bit_ops_pkg::carry_clear_instr:
        begin
          nxt_res.rung_out = 1'b1;
          nxt_carry        = 1'b0;                       // see RULE8
        end
        bit_ops_pkg::priority_encode_instr:
        begin
          if (enc_found && n_ok)
          begin
            nxt_res.rung_out = 1'b1;                     // see RULE9
            nxt_res.dest_we  = 1'b1;
            nxt_res.dest_val = {{PAD_W{1'b0}}, enc_pos};
          end
          else
          begin
            // empty table: destination untouched, error latched
            nxt_err = 1'b1;                              // see RULE11
          end
        end
        default:
        begin
          nxt_res = '0;
        end
      endcase
    end
    // rung off: no strobes, flags kept, output off; see RULE12 RULE6
  end

  // register stage
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      res_ff   <= '0;
      carry_ff <= 1'b0;
      err_ff   <= 1'b0;
    end
    else
    begin
      res_ff   <= nxt_res;
      carry_ff <= nxt_carry;
      err_ff   <= nxt_err;
    end
  end

  assign result         = res_ff;
  assign carry_flag_bit = carry_ff;
  assign error_flag_bit = err_ff;

  // checks on the registered write-back one edge after the request, and on the encoder pick in the request cycle

  // compare request taken this cycle
  sequence s_cmp_req;
    instr.rung_in && instr.op == bit_ops_pkg::OP_UNSIGNED_LE;
  endsequence

  // answer is a <= b on the operands taken one edge earlier
  property p_cmp;
    @(posedge clk) disable iff (reset)
    s_cmp_req |=>
      result.rung_out == ($past(instr.opnd_a) <= $past(instr.opnd_b));
  endproperty
  a_cmp: assert property (p_cmp) // see RULE1
    else $error("compare wrong");

  // nothing exceeds the top of the unsigned range
  property p_cmp_max;
    @(posedge clk) disable iff (reset)
    s_cmp_req ##0 instr.opnd_b == bit_ops_pkg::WORD_ONES |=>
      result.rung_out;
  endproperty
  a_cmp_max: assert property (p_cmp_max) // see RULE2
    else $error("max not le");

  // force-on request taken this cycle
  sequence s_force_on;
    instr.rung_in && instr.op == bit_ops_pkg::OP_FORCE_ON;
  endsequence

  // register form writes the all-ones word, no bit strobe
  property p_set_reg;
    @(posedge clk) disable iff (reset)
    s_force_on ##0 instr.is_reg |=>
      result.word_we && result.word_val == bit_ops_pkg::WORD_ONES &&
      !result.bit_we;
  endproperty
  a_set_reg: assert property (p_set_reg) // see RULE4
    else $error("set reg");

  // bit form writes one bit on, no word strobe
  property p_set_bit;
    @(posedge clk) disable iff (reset)
    s_force_on ##0 !instr.is_reg |=>
      result.bit_we && result.bit_val && !result.word_we;
  endproperty
  a_set_bit: assert property (p_set_bit) // see RULE3
    else $error("set bit");

  // force-off writes zero in either form
  property p_rst;
    @(posedge clk) disable iff (reset)
    instr.rung_in && instr.op == bit_ops_pkg::OP_FORCE_OFF |=>
      result.rung_out && !result.bit_val &&
      result.word_val == bit_ops_pkg::WORD_ZERO;
  endproperty
  a_rst: assert property (p_rst) // see RULE5
    else $error("reset op");

  // rung off: the unit must not disturb anything
  sequence s_idle;
    !instr.rung_in;
  endsequence
  property p_hold;
    @(posedge clk) disable iff (reset)
    s_idle |=> !result.rung_out && !result.bit_we && !result.word_we &&
      !result.dest_we && $stable(carry_flag_bit) && $stable(error_flag_bit);
  endproperty
  a_hold: assert property (p_hold) // see RULE12
    else $error("idle changed");

  // carry set raises the flag and the output
  property p_carry;
    @(posedge clk) disable iff (reset)
    instr.rung_in && instr.op == bit_ops_pkg::carry_set_instr |=>
      carry_flag_bit && result.rung_out;
  endproperty
  a_carry: assert property (p_carry) // see RULE7
    else $error("carry set");

  // carry clear drops the flag, output still on
  property p_carry_clr;
    @(posedge clk) disable iff (reset)
    instr.rung_in && instr.op == bit_ops_pkg::carry_clear_instr |=>
      !carry_flag_bit && result.rung_out;
  endproperty
  a_carry_clr: assert property (p_carry_clr) // see RULE8
    else $error("carry clr");

  // empty or refused table: no write, output off, error raised
  property p_enc_empty;
    @(posedge clk) disable iff (reset)
    instr.rung_in && instr.op == bit_ops_pkg::priority_encode_instr &&
      !(enc_found && n_ok) |=>
      error_flag_bit && !result.dest_we && !result.rung_out;
  endproperty
  a_enc_empty: assert property (p_enc_empty) // see RULE11
    else $error("enc empty");

  // encode request that finds an on bit inside a legal window
  sequence s_enc_hit;
    instr.rung_in && instr.op == bit_ops_pkg::priority_encode_instr &&
      enc_found && n_ok;
  endsequence

  // the picked bit is on and no bit above it in the window is on
  property p_enc_pick;
    @(posedge clk) disable iff (reset)
    s_enc_hit |-> ((enc_table & win_chk) >> enc_pos) == TBL'(1);
  endproperty
  a_enc_pick: assert property (p_enc_pick) // see RULE9
    else $error("enc pick");

  // the position is written back one edge later, zero-extended
  property p_enc;
    @(posedge clk) disable iff (reset)
    s_enc_hit |=> result.dest_we && result.rung_out &&
      result.dest_val == {{PAD_W{1'b0}}, $past(enc_pos)};
  endproperty
  a_enc: assert property (p_enc) // see RULE9
    else $error("enc write");
endmodule : plc_bit_compare_encode_unit

// ===== tb/seq_model.sv
// sequencer model: presents instructions and the encoder table
`timescale 1ns/100ps
module seq_model #(
  parameter int unsigned TBL = bit_ops_pkg::TABLE_MAX
) (
  // clock
  input  wire logic            clk,
  // request towards the unit
  output bit_ops_pkg::instr_s  instr,
  output logic [TBL-1:0]       enc_table
);
  // idle at time zero: rung off, no instruction
  initial
  begin
    instr     = '0;
    enc_table = '0;
  end

  // one request held for one taking edge, then released
  task automatic issue(input logic rung, input bit_ops_pkg::op_e op,
    input logic isr, input logic [15:0] a, input logic [15:0] b,
    input logic [3:0] n, input logic [TBL-1:0] tbl);
    @(posedge clk);
    instr     <= '{rung, op, isr, a, b, n};
    enc_table <= tbl;
    @(posedge clk);
    // released lines carry inverted junk, so stale values never help
    instr     <= '{1'b0, bit_ops_pkg::OP_NONE, ~isr, ~a, ~b, ~n};
    enc_table <= ~tbl;
    #1;
  endtask : issue
endmodule : seq_model

// ===== tb/plc_bit_compare_encode_unit_tb.sv
// testbench: compare, force, carry and encode instructions
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: value mismatch", $time); end end
module plc_bit_compare_encode_unit_tb;
  logic                 clk = 1'b0;   // 40 MHz clock
  logic                 reset = 1'b1; // held for 20 cycles
  bit_ops_pkg::instr_s  instr;        // from the sequencer model
  logic [255:0]         enc_table;    // encoder table
  bit_ops_pkg::result_s result;       // write-back
  logic                 carry_flag_bit;
  logic                 error_flag_bit;
  int                   fails = 0;
  int                   checked = 0;

  // free-running clock
  always #12.5 clk = ~clk;

  seq_model u_seq_model (.clk(clk), .instr(instr), .enc_table(enc_table));

  plc_bit_compare_encode_unit u_plc_bit_compare_encode_unit (
    .clk(clk), .reset(reset), .instr(instr), .enc_table(enc_table),
    .result(result), .carry_flag_bit(carry_flag_bit),
    .error_flag_bit(error_flag_bit));

  // verdict and end of run, shared with the watchdog
  task tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // unsigned compare, values above the signed range on purpose
  task test_compare;
    logic [15:0] av [4] = '{16'h88b8, 16'h0000, 16'hffff, 16'h9c41};
    logic [15:0] bv [4] = '{16'h88b8, 16'hffff, 16'h0000, 16'h9c40};
    logic        ev [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++)
    begin
      u_seq_model.issue(1'b1, bit_ops_pkg::OP_UNSIGNED_LE, 1'b0, av[i],
        bv[i], 4'h0, '0);
      `CHK(result.rung_out, ev[i])
      u_seq_model.issue(1'b0, bit_ops_pkg::OP_UNSIGNED_LE, 1'b0, av[i],
        bv[i], 4'h0, '0);
      `CHK(result.rung_out, 1'b0)
    end
    $display("test compare done");
  endtask : test_compare

  // bit and register forms of force-on and force-off
  task test_force;
    bit_ops_pkg::op_e op;
    for (int i = 0; i < 4; i++)
    begin
      op = i[1] ? bit_ops_pkg::OP_FORCE_OFF : bit_ops_pkg::OP_FORCE_ON;
      u_seq_model.issue(1'b1, op, i[0], 16'h1234, 16'h0, 4'h0, '0);
      `CHK(result.rung_out, 1'b1)
      `CHK(result.bit_we, ~i[0])
      `CHK(result.word_we, i[0])
      if (i[0])
        `CHK(result.word_val, i[1] ? 16'h0000 : 16'hffff)
      else
        `CHK(result.bit_val, ~i[1])
      // rung off afterwards: no rewrite, so the stored value stays
      u_seq_model.issue(1'b0, op, i[0], 16'h1234, 16'h0, 4'h0, '0);
      `CHK({result.rung_out, result.bit_we, result.word_we}, 3'h0)
    end
    $display("test force done");
  endtask : test_force

  // carry flag set and clear, each followed by a gated-off request of the opposite kind
  task test_carry;
    u_seq_model.issue(1'b1, bit_ops_pkg::carry_set_instr, 1'h0, 16'h0000,
      16'h0000, 4'h0, '0);
    `CHK({result.rung_out, carry_flag_bit}, 2'h3)
    u_seq_model.issue(1'b0, bit_ops_pkg::carry_clear_instr, 1'h0, 16'h0000,
      16'h0000, 4'h0, '0);
    `CHK({result.rung_out, carry_flag_bit}, 2'h1)
    u_seq_model.issue(1'b1, bit_ops_pkg::carry_clear_instr, 1'h0, 16'h0000,
      16'h0000, 4'h0, '0);
    `CHK({result.rung_out, carry_flag_bit}, 2'h2)
    u_seq_model.issue(1'b0, bit_ops_pkg::carry_set_instr, 1'h0, 16'h0000,
      16'h0000, 4'h0, '0);
    `CHK({result.rung_out, carry_flag_bit}, 2'h0)
    $display("test carry done");
  endtask : test_carry

  // one encode with a found bit; checks position and strobe
  task enc_one(input logic [3:0] n, input logic [255:0] t,
    input logic [15:0] pos);
    u_seq_model.issue(1'b1, bit_ops_pkg::priority_encode_instr, 1'h0,
      16'h0000, 16'h0000, n, t);
    `CHK({result.rung_out, result.dest_we}, 2'h3)
    `CHK(result.dest_val, pos)
  endtask : enc_one

  // encoder sizes at both ends, bits beyond the table ignored
  task test_encode;
    `CHK(error_flag_bit, 1'b0)
    enc_one(4'h5, (256'h1 << 20) | (256'h1 << 40), 16'h0014);
    enc_one(4'h8, (256'h1 << 255) | 256'h3, 16'h00ff);
    enc_one(4'h1, 256'h6, 16'h0001);
    enc_one(4'h4, 256'h1, 16'h0000);
    // size code nine lies outside 1..8: refused and flagged like empty
    u_seq_model.issue(1'b1, bit_ops_pkg::priority_encode_instr, 1'h0,
      16'h0000, 16'h0000, 4'h9, 256'h1);
    `CHK({result.rung_out, result.dest_we, error_flag_bit}, 3'h1)
    // mid-run reset clears the sticky error flag before the empty case
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    `CHK({result, carry_flag_bit, error_flag_bit}, '0)
    // empty table: only a bit outside the 32-bit window is on
    u_seq_model.issue(1'b1, bit_ops_pkg::priority_encode_instr, 1'h0,
      16'h0000, 16'h0000, 4'h5, 256'h1 << 40);
    `CHK({result.rung_out, result.dest_we, error_flag_bit}, 3'h1)
    $display("test encode done");
  endtask : test_encode

  // watchdog: the whole run needs well under 300 cycles
  initial
  begin
    repeat (2000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    #1;
    `CHK({result, carry_flag_bit, error_flag_bit}, '0)
    test_compare();
    test_force();
    test_carry();
    test_encode();
    tally_and_finish();
  end
endmodule : plc_bit_compare_encode_unit_tb
